/* hdl/erx_cfg.svh */
// Offsets, field positions, masks and counts of the receive descriptor manager
`ifndef ERX_CFG_SVH
`define ERX_CFG_SVH

// APB register byte offsets
`define ERX_CTRL_OFS 12'h000
`define ERX_CFG_OFS 12'h004
`define ERX_STAT_OFS 12'h008
`define ERX_QPTR_OFS 12'h00c
`define ERX_RERR_OFS 12'h010

// Control and configuration fields
`define ERX_CTRL_RXEN 0
`define ERX_CFG_JUMBO 3
`define ERX_CFG_OFF_LO 14
`define ERX_CFG_OFF_HI 15
`define ERX_CFG_STRIP 17
`define ERX_CFG_MASK 32'h0002_c008

// Receive status fields, write one to clear
`define ERX_STAT_BNA 0
`define ERX_STAT_FRM 1
`define ERX_STAT_OVR 2

// Descriptor layout
`define ERX_D0_USED 0
`define ERX_D0_WRAP 1
`define ERX_D1_OFS 32'h0000_0004

// Buffer, check sequence and bus timing
`define ERX_BUF_BYTES 8'h80
`define ERX_FCS_BYTES 4
`define ERX_FCS_LEN 14'h0004
`define ERX_GNT_WAIT 16
`define ERX_DESC_STEP 11'h002

`endif

/* hdl/erx_pkg.sv */
// Types shared by the receive descriptor manager files
package erx_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_FILT = 3'b010,
        ST_DATA = 3'b011,
        ST_WBYTE = 3'b100,
        ST_STAT = 3'b101,
        ST_USED = 3'b110,
        ST_DROP = 3'b111
    } erx_state_e;

    // Memory request: held until answered or until the grant wait times out
    typedef struct packed {
        logic req;
        logic we;
        logic byte_sz;
        logic [31:0] addr;
        logic [31:0] wdata;
    } erx_mreq_s;

    // Memory answer: one-cycle ack with read data or error
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } erx_mrsp_s;

    // Frame status from the receive and filter logic, status word bits 31:16
    typedef struct packed {
        logic [9:0] match;
        logic vlan;
        logic prio_tag;
        logic [2:0] prio;
        logic cfi;
    } erx_rxst_s;
endpackage

/* hdl/erx_fcs_hold.sv */
// Byte delay line that withholds the last DEPTH bytes of a frame when stripping is on
`timescale 1ns/1ps
module erx_fcs_hold #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input logic mclk,
    input logic rst,
    // Control
    input logic flush,
    input logic strip,
    // Byte stream in
    input logic in_valid,
    input logic [W-1:0] in_data,
    output logic in_ready,
    // Byte stream out
    output logic out_valid,
    output logic [W-1:0] out_data,
    input logic out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0] sh_reg [DEPTH];
    logic [CW-1:0] cnt_reg;
    wire full = (cnt_reg == CW'(DEPTH));
    wire shift = in_valid & in_ready & strip;

    assign out_valid = in_valid & (~strip | full);
    assign out_data = strip ? sh_reg[DEPTH-1] : in_data;
    assign in_ready = (strip & ~full) | out_ready;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (flush) begin
            cnt_reg <= '0;
        end else if (shift && !full) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (shift) begin
            sh_reg[0] <= in_data;
            for (int i = 1; i < DEPTH; i++) begin
                sh_reg[i] <= sh_reg[i-1];
            end
        end
    end
endmodule

/* hdl/erx_desc_ptr.sv */
// Descriptor list pointer: programmed base plus an 11-bit word counter
`timescale 1ns/1ps
`include "erx_cfg.svh"
module erx_desc_ptr #(
    parameter int CW = 11
) (
    // Clock and reset
    input logic mclk,
    input logic rst,
    // Base load and advance
    input logic load,
    input logic [31:0] base,
    input logic advance,
    input logic wrap,
    // Pointer
    output logic [31:0] ptr,
    output logic [CW-1:0] cnt
);
    logic [31:0] base_reg;
    logic [CW-1:0] cnt_reg;

    assign ptr = base_reg + {{(30-CW){1'b0}}, cnt_reg, 2'b00};
    assign cnt = cnt_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            base_reg <= 32'h0000_0000;
            cnt_reg <= '0;
        end else if (load) begin
            base_reg <= {base[31:2], 2'b00};
            cnt_reg <= '0;
        end else if (advance) begin
            // Two words per entry; the counter rolls over after 1024 entries
            cnt_reg <= wrap ? '0 : cnt_reg + CW'(`ERX_DESC_STEP);
        end
    end
endmodule

/* hdl/erx_desc_mgr.sv */
// Receive buffer manager and receive data DMA with APB registers
//
// Functional notes
// R1 - Status bit 16 carries the VLAN CFI bit, valid only with bit 21.
// R2 - Status bit 15 marks end of frame; otherwise only bits 14:12 valid.
// R3 - Status bit 14 marks start of frame; both set means a whole frame.
// R4 - Status bits 13:12 give the first-buffer byte offset in normal mode.
// R5 - In jumbo mode status bits 13:12 hold frame length bits 13:12.
// R6 - Status bits 11:0 hold frame length, including stored check sequence.
// R7 - Software writes buffer address, used bit zero, wrap on last entry.
// R8 - Software loads the list base before enabling receive.
// R9 - Descriptor fetch starts as soon as a frame begins arriving.
// R10 - Data is stored only for frames the filter accepts; errors reclaim.
// R11 - After wrap or the 1024th entry the next fetch is the list start.
// R12 - Pointer is base plus an 11-bit word count; readback shows it.
// R13 - Count clears after status to a wrap entry, rolls after 1024 entries.
// R14 - Software keeps the base word aligned with 2048 words above it.
// R15 - Each consumed buffer gets its used bit set in word zero.
// R16 - A receive error reclaims only the buffer being written.
// R17 - Software counts frames from used, start and end bits.
// R18 - A used descriptor is skipped, flags buffer-not-available, raises event. Here the frame is dropped and the pointer stays on that descriptor.
// R19 - A used descriptor during a frame drops it and counts a resource error.
// R20 - Bus timeout or error flags overrun and reclaims the current buffer.
// R21 - Strip mode keeps the check sequence out and shortens length by four.
// R22 - Buffers are 128 bytes; the first one loses the start offset.
// R23 - Non-final status words hold only start of frame and offset.
// R24 - Start offset of zero to three bytes comes from config bits 15:14.
// R25 - Status and used bit are written after all buffer data.
`timescale 1ns/1ps
`include "erx_cfg.svh"
module erx_desc_mgr #(
    parameter int GNT_WAIT = `ERX_GNT_WAIT
) (
    // Clock and reset
    input logic mclk,
    input logic rst,
    // APB slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Frame stream from the receive logic
    input logic rx_start,
    input logic rx_valid,
    input logic [7:0] rx_byte,
    output logic rx_ready,
    input logic rx_end,
    input erx_pkg::erx_rxst_s rx_stat,
    input logic rx_err,
    input logic flt_valid,
    input logic flt_copy,
    // Memory master
    output erx_pkg::erx_mreq_s mreq,
    input erx_pkg::erx_mrsp_s mrsp,
    // Events
    output logic bna_evt,
    output logic ovr_evt,
    output logic frm_evt,
    output logic rerr_evt
);
    import erx_pkg::*;

    erx_state_e state_reg, state_next;
    logic rxen_reg;
    logic [31:0] cfg_reg;
    logic [2:0] stat_reg;
    logic [15:0] rerr_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [29:0] buf_reg;
    logic wrap_reg, first_reg, fin_reg, end_reg, err_reg;
    logic [7:0] pos_reg, wbyte_reg, tmo_reg;
    logic [13:0] len_reg;
    logic bna_reg, ovr_reg, frm_reg, rerr_ev_reg;
    logic [31:0] ptr;
    logic [10:0] cnt;
    logic h_valid, h_ready;
    logic [7:0] h_data;

    // APB decode
    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pwrite;
    wire a_ctrl = (paddr == `ERX_CTRL_OFS);
    wire a_cfg = (paddr == `ERX_CFG_OFS);
    wire a_stat = (paddr == `ERX_STAT_OFS);
    wire a_qptr = (paddr == `ERX_QPTR_OFS);
    wire a_rerr = (paddr == `ERX_RERR_OFS);
    wire a_hit = a_ctrl | a_cfg | a_stat | a_qptr | a_rerr;
    wire [31:0] rd_mux = a_ctrl ? {31'h0, rxen_reg} :
                         a_cfg ? cfg_reg :
                         a_stat ? {29'h0, stat_reg} :
                         a_qptr ? ptr :                            // [R12]
                         a_rerr ? {16'h0, rerr_reg} : 32'h0;
    wire qptr_wr = wr_acc & a_qptr;
    wire stat_clr_bna = wr_acc & a_stat & pwdata[`ERX_STAT_BNA];
    wire stat_clr_frm = wr_acc & a_stat & pwdata[`ERX_STAT_FRM];
    wire stat_clr_ovr = wr_acc & a_stat & pwdata[`ERX_STAT_OVR];
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // Configuration fields
    wire jumbo = cfg_reg[`ERX_CFG_JUMBO];
    wire strip = cfg_reg[`ERX_CFG_STRIP];
    wire [1:0] off = cfg_reg[`ERX_CFG_OFF_HI:`ERX_CFG_OFF_LO];       // [R24]

    // Memory handshake
    wire ack = mrsp.ack;
    wire ack_ok = ack & ~mrsp.err;
    wire mem_st = (state_reg == ST_FETCH) | (state_reg == ST_WBYTE) |
                  (state_reg == ST_STAT) | (state_reg == ST_USED);
    wire tmo_hit = mem_st & ~ack & (tmo_reg == 8'(GNT_WAIT - 1));
    wire bus_fail = mem_st & ((ack & mrsp.err) | tmo_hit);            // [R20]
    wire fetch_used = (state_reg == ST_FETCH) & ack_ok & mrsp.rdata[`ERX_D0_USED];
    wire buf_full = (pos_reg == `ERX_BUF_BYTES);                       // [R22]
    wire frame_done = end_reg | err_reg | rx_end | rx_err;

    // Frame length and status word
    wire [13:0] len_rep = strip ? len_reg - `ERX_FCS_LEN : len_reg;   // [R21] [R6]
    wire [1:0] f1312 = jumbo ? len_rep[13:12] : (first_reg ? off : 2'b00); // [R4] [R5]
    wire [31:0] st_fin = {rx_stat, 1'b1, first_reg, f1312, len_rep[11:0]}; // [R1] [R2] [R3]
    wire [31:0] st_mid = {16'h0, 1'b0, first_reg, off & {2{first_reg}}, 12'h0}; // [R23]
    wire [31:0] st_word = fin_reg ? st_fin : st_mid;

    // Byte acceptance
    wire in_take = rx_valid & rx_ready;
    wire drain = (state_reg == ST_DROP) | (state_reg == ST_IDLE);
    wire byte_take = (state_reg == ST_DATA) & h_valid & ~buf_full & ~err_reg;
    assign h_ready = byte_take | drain;
    wire advance = (state_reg == ST_USED) & ack_ok;                   // [R13]

    // Memory request
    always_comb begin
        mreq = '0;
        mreq.req = mem_st;
        mreq.we = (state_reg != ST_FETCH);
        mreq.byte_sz = (state_reg == ST_WBYTE);
        unique case (state_reg)
            ST_FETCH: mreq.addr = ptr;
            ST_WBYTE: mreq.addr = {buf_reg, 2'b00} + {24'h0, pos_reg};
            ST_STAT: mreq.addr = ptr + `ERX_D1_OFS;
            default: mreq.addr = ptr;
        endcase
        unique case (state_reg)
            ST_WBYTE: mreq.wdata = {4{wbyte_reg}};
            ST_STAT: mreq.wdata = st_word;
            default: mreq.wdata = {buf_reg, wrap_reg, 1'b1};          // [R15]
        endcase
    end

    // Sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: if (rx_start && rxen_reg) state_next = ST_FETCH;     // [R9]
            ST_FETCH: begin
                if (bus_fail || fetch_used) begin
                    state_next = ST_DROP;                                 // [R18] [R19]
                end else if (ack_ok) begin
                    state_next = first_reg ? ST_FILT : ST_DATA;
                end
            end
            ST_FILT: begin
                if (err_reg) begin
                    state_next = ST_DROP;
                end else if (flt_valid) begin
                    state_next = flt_copy ? ST_DATA : ST_DROP;            // [R10]
                end
            end
            ST_DATA: begin
                if (err_reg) begin
                    state_next = ST_DROP;                                 // [R16]
                end else if (h_valid && buf_full) begin
                    state_next = ST_STAT;
                end else if (h_valid) begin
                    state_next = ST_WBYTE;
                end else if (end_reg) begin
                    state_next = ST_STAT;                                 // [R25]
                end
            end
            ST_WBYTE: begin
                if (bus_fail) begin
                    state_next = ST_DROP;
                end else if (ack_ok) begin
                    state_next = ST_DATA;
                end
            end
            ST_STAT: begin
                if (bus_fail) begin
                    state_next = ST_DROP;
                end else if (ack_ok) begin
                    state_next = ST_USED;
                end
            end
            ST_USED: begin
                if (bus_fail) begin
                    state_next = ST_DROP;
                end else if (ack_ok) begin
                    state_next = fin_reg ? ST_IDLE : ST_FETCH;            // [R11]
                end
            end
            ST_DROP: if (frame_done) state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            tmo_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            tmo_reg <= (state_next != state_reg || !mem_st) ? 8'h00 : tmo_reg + 8'h01;
        end
    end

    // Buffer and frame bookkeeping
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buf_reg <= 30'h0;
            wrap_reg <= 1'b0;
            first_reg <= 1'b1;
            fin_reg <= 1'b0;
            pos_reg <= 8'h00;
            wbyte_reg <= 8'h00;
        end else begin
            if (state_reg == ST_IDLE) begin
                first_reg <= 1'b1;
                fin_reg <= 1'b0;
            end
            if (state_reg == ST_FETCH && ack_ok) begin
                buf_reg <= mrsp.rdata[31:2];
                wrap_reg <= mrsp.rdata[`ERX_D0_WRAP];
                pos_reg <= first_reg ? {6'h0, off} : 8'h00;               // [R22]
            end
            if (byte_take) wbyte_reg <= h_data;
            if (state_reg == ST_WBYTE && ack_ok) pos_reg <= pos_reg + 8'h01;
            if (state_reg == ST_DATA && !h_valid && end_reg) fin_reg <= 1'b1;
            if (advance) first_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            len_reg <= 14'h0;
            end_reg <= 1'b0;
            err_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            len_reg <= 14'h0;
            end_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            if (in_take) len_reg <= len_reg + 14'h1;
            if (rx_end) end_reg <= 1'b1;
            if (rx_err) err_reg <= 1'b1;
        end
    end

    // Events
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bna_reg <= 1'b0;
            ovr_reg <= 1'b0;
            frm_reg <= 1'b0;
            rerr_ev_reg <= 1'b0;
        end else begin
            bna_reg <= fetch_used;                                         // [R18]
            ovr_reg <= bus_fail;                                           // [R20]
            frm_reg <= advance & fin_reg;
            rerr_ev_reg <= fetch_used;                                     // [R19]
        end
    end
    assign bna_evt = bna_reg;
    assign ovr_evt = ovr_reg;
    assign frm_evt = frm_reg;
    assign rerr_evt = rerr_ev_reg;

    // Registers; a hardware set wins over a software clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxen_reg <= 1'b0;
            cfg_reg <= 32'h0;
            stat_reg <= 3'h0;
            rerr_reg <= 16'h0;
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            if (wr_acc && a_ctrl) rxen_reg <= pwdata[`ERX_CTRL_RXEN];
            if (wr_acc && a_cfg) cfg_reg <= pwdata & `ERX_CFG_MASK;
            stat_reg[`ERX_STAT_BNA] <= bna_reg | (stat_reg[`ERX_STAT_BNA] & ~stat_clr_bna);
            stat_reg[`ERX_STAT_FRM] <= frm_reg | (stat_reg[`ERX_STAT_FRM] & ~stat_clr_frm);
            stat_reg[`ERX_STAT_OVR] <= ovr_reg | (stat_reg[`ERX_STAT_OVR] & ~stat_clr_ovr);
            if (fetch_used) rerr_reg <= rerr_reg + 16'h1;                 // [R19]
            if (setup) begin
                prdata_reg <= rd_mux;
                pslverr_reg <= ~a_hit;
            end
        end
    end

    erx_fcs_hold #(.W(8), .DEPTH(`ERX_FCS_BYTES)) u_hold (
        .mclk(mclk),
        .rst(rst),
        .flush(rx_start),
        .strip(strip),                                                     // [R21]
        .in_valid(rx_valid),
        .in_data(rx_byte),
        .in_ready(rx_ready),
        .out_valid(h_valid),
        .out_data(h_data),
        .out_ready(h_ready)
    );

    erx_desc_ptr #(.CW(11)) u_ptr (
        .mclk(mclk),
        .rst(rst),
        .load(qptr_wr),
        .base(pwdata),
        .advance(advance),                                                 // [R11] [R12]
        .wrap(wrap_reg),
        .ptr(ptr),
        .cnt(cnt)
    );

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    used_mark_a: assert property (state_reg == ST_USED |-> mreq.wdata[0] && mreq.we) // [R15]
        else $error("used bit not set in descriptor write");
    eof_mark_a: assert property (state_reg == ST_STAT && fin_reg |-> mreq.wdata[15]) // [R2]
        else $error("final status lacks end of frame");
    mid_status_a: assert property (state_reg == ST_STAT && !fin_reg |->   // [R23]
        mreq.wdata[31:15] == 17'h0 && mreq.wdata[11:0] == 12'h0)
        else $error("non-final status carries extra bits");
    jumbo_len_a: assert property (state_reg == ST_STAT && fin_reg && jumbo |-> // [R5]
        mreq.wdata[13:12] == len_rep[13:12])
        else $error("jumbo length bits wrong");
    strip_len_a: assert property (state_reg == ST_STAT && fin_reg && strip |-> // [R21]
        mreq.wdata[11:0] == 12'(len_reg - `ERX_FCS_LEN))
        else $error("stripped length not four shorter");
    bna_flag_a: assert property (fetch_used |=> ##1 stat_reg[`ERX_STAT_BNA]) // [R18]
        else $error("buffer not available flag missing");
    rerr_count_a: assert property (fetch_used |=> rerr_reg == $past(rerr_reg) + 16'h1) // [R19]
        else $error("resource error count not advanced");
    wrap_clear_a: assert property (advance && wrap_reg && !qptr_wr |=> cnt == 11'h0) // [R13]
        else $error("counter not cleared after wrap");
    step_next_a: assert property (advance && !wrap_reg && !qptr_wr |=>    // [R11]
        cnt == 11'($past(cnt) + `ERX_DESC_STEP))
        else $error("pointer not on next entry");
    stat_after_a: assert property ($rose(state_reg == ST_STAT) |->        // [R25]
        $past(state_reg) == ST_DATA)
        else $error("status written before buffer data");
    room_left_a: assert property (state_reg == ST_WBYTE |-> pos_reg < `ERX_BUF_BYTES) // [R22]
        else $error("byte written past buffer end");
    ovr_flag_a: assert property (bus_fail |=> ##1 stat_reg[`ERX_STAT_OVR]) // [R20]
        else $error("overrun flag missing");

    whole_frame_c: cover property (advance && fin_reg && first_reg);
    multi_buf_c: cover property (advance && fin_reg && !first_reg);
    bna_seen_c: cover property (fetch_used);
    overrun_c: cover property (bus_fail);
endmodule

/* test/erx_mem_model.sv */
// Memory model answering the manager's descriptor and buffer traffic
`timescale 1ns/1ps
module erx_mem_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Request and answer
    input wire erx_pkg::erx_mreq_s mreq,
    output erx_pkg::erx_mrsp_s mrsp
);
    import erx_pkg::*;
    logic [31:0] mem [0:1023];
    logic err_next;
    int wait_cnt;
    wire [9:0] idx = mreq.addr[11:2];
    wire [4:0] sh = {mreq.addr[1:0], 3'b000};
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            mrsp <= '0;
            err_next <= 1'b0;
            wait_cnt <= 0;
        end else if (mrsp.ack || !mreq.req) begin
            // Idle read data keeps changing so a stale word is never mistaken for an answer
            mrsp <= {2'b00, ~mrsp.rdata};
            wait_cnt <= $urandom_range(3, 0);
        end else if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
        else begin
            mrsp <= {1'b1, err_next & mreq.we, mem[idx]};
            if (mreq.we)
                err_next <= 1'b0;
            if (mreq.we && !err_next && mreq.byte_sz)
                mem[idx][sh +: 8] <= mreq.wdata[sh +: 8];
            else if (mreq.we && !err_next)
                mem[idx] <= mreq.wdata;
        end
    end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the receive descriptor manager
`timescale 1ns/1ps
`include "erx_cfg.svh"
module tb_top;
    import erx_pkg::*;
    logic mclk = 1'b0;
    logic rst, psel, penable, pwrite, pready, pslverr, jumbo, strip;
    logic rx_start, rx_valid, rx_ready, rx_end, rx_err, flt_valid, flt_copy;
    logic bna_evt, ovr_evt, frm_evt, rerr_evt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] rx_byte;
    logic [7:0] fb [0:255];
    logic [1:0] ofs;
    logic [3:0] seen;
    erx_rxst_s rx_stat;
    erx_mreq_s mreq;
    erx_mrsp_s mrsp;
    int mismatches = 0;
    int cmp_count = 0;
    int di = 0;

    always #2 mclk = ~mclk;
    always @(posedge mclk) seen <= seen | {rerr_evt, frm_evt, ovr_evt, bna_evt};

    erx_desc_mgr #(.GNT_WAIT(8)) uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_start(rx_start), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_ready(rx_ready), .rx_end(rx_end), .rx_stat(rx_stat), .rx_err(rx_err),
        .flt_valid(flt_valid), .flt_copy(flt_copy), .mreq(mreq), .mrsp(mrsp),
        .bna_evt(bna_evt), .ovr_evt(ovr_evt), .frm_evt(frm_evt), .rerr_evt(rerr_evt));
    erx_mem_model mm (.mclk(mclk), .rst(rst), .mreq(mreq), .mrsp(mrsp));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] bufa(input int d);
        return 32'h200 + 32'(d) * 32'h80;
    endfunction

    function automatic logic [31:0] exp_stat(input int len, input bit first, input bit last);
        logic [31:0] s;
        logic [13:0] l;
        s = '0;
        l = 14'(strip ? len - 4 : len);
        s[14] = first;
        if (first)
            s[13:12] = ofs;
        if (last) begin
            s[31:16] = rx_stat;
            s[15] = 1'b1;
            s[11:0] = l[11:0];
            if (jumbo)
                s[13:12] = l[13:12];
        end
        return s;
    endfunction

    task automatic run_frame(input int len, input bit copy, input int errat, input bit used,
                             input bit ovr);
        int stored, cap, nb, d;
        logic [31:0] ba;
        stored = strip ? len - 4 : len;
        cap = 128 - ofs;
        nb = (used || ovr || !copy) ? 0 : (errat > cap + 8) ? 1 : (errat >= 0) ? 0 :
             (stored > cap) ? 2 : 1;
        if (used)
            mm.mem[2 * di][0] = 1'b1;
        mm.err_next = ovr;
        for (int k = 0; k < len; k++)
            fb[k] = 8'($urandom);
        // Cleared away from the clock edge so the event collector cannot undo it
        @(negedge mclk);
        seen = '0;
        @(posedge mclk);
        rx_stat <= 16'($urandom);
        rx_start <= 1'b1;
        @(posedge mclk);
        rx_start <= 1'b0;
        do @(negedge mclk); while (mrsp.ack !== 1'b1);
        @(posedge mclk);
        flt_valid <= 1'b1;
        flt_copy <= copy;
        @(posedge mclk);
        flt_valid <= 1'b0;
        for (int k = 0; k < len; k++) begin
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_byte <= fb[k];
            rx_err <= (k == errat);
            do @(negedge mclk); while (rx_ready !== 1'b1);
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_err <= 1'b0;
        rx_end <= 1'b1;
        @(posedge mclk);
        rx_end <= 1'b0;
        for (int i = 0; i < 300 && !seen[2]; i++)
            @(negedge mclk);
        check("events", {28'h0, used, copy && !used && !ovr && errat < 0, ovr, used},
              {28'h0, seen});
        for (int i = 0; i < nb; i++) begin
            d = (di + i) % 4;
            ba = bufa(d);
            check("word0", {ba[31:2], d == 3, 1'b1}, mm.mem[2 * d]);
            check("status", exp_stat(len, i == 0, i == nb - 1 && errat < 0),
                  mm.mem[2 * d + 1]);
            // Hand the consumed descriptor back, as software would
            mm.mem[2 * d][0] = 1'b0;
        end
        for (int k = 0; k < stored && nb > 0 && errat < 0; k++) begin
            ba = (k < cap) ? bufa(di) + ofs + k : bufa((di + 1) % 4) + k - cap;
            check("byte", {24'h0, fb[k]}, {24'h0, mm.mem[ba[11:2]][8 * ba[1:0] +: 8]});
        end
        di = (di + nb) % 4;
        if (used)
            mm.mem[2 * di][0] = 1'b0;
        apb(1'b0, `ERX_QPTR_OFS, 32'h0);
        check("queue pointer", 32'(di * 8), r);
    endtask

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, rx_start, rx_valid, rx_end, rx_err, flt_valid, flt_copy} = '0;
        {paddr, pwdata, rx_byte, rx_stat, seen, ofs, jumbo, strip} = '0;
        void'($urandom(74));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            r = bufa(i);
            mm.mem[2 * i] = {r[31:2], i == 3, 1'b0};
        end
        apb(1'b0, `ERX_STAT_OFS, 32'h0);
        check("status reg reset", 32'h0, r);
        apb(1'b1, `ERX_QPTR_OFS, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0);
        check("unmapped slverr", 32'h1, {31'h0, pslverr});
        apb(1'b1, `ERX_CTRL_OFS, 32'h1);
        for (int t = 0; t < 12; t++) begin
            ofs = 2'($urandom);
            jumbo = t[0];
            strip = t[1];
            apb(1'b1, `ERX_CFG_OFS, {14'h0, strip, 1'b0, ofs, 10'h0, jumbo, 3'h0});
            run_frame(t % 3 == 0 ? 200 : $urandom_range(60, 8), 1'b1, -1, 1'b0, 1'b0);
        end
        run_frame(40, 1'b0, -1, 1'b0, 1'b0);
        run_frame(40, 1'b1, -1, 1'b1, 1'b0);
        apb(1'b0, `ERX_STAT_OFS, 32'h0);
        check("not available flag", 32'h1, r & 32'h1);
        apb(1'b0, `ERX_RERR_OFS, 32'h0);
        check("resource errors", 32'h1, r);
        run_frame(40, 1'b1, -1, 1'b0, 1'b1);
        apb(1'b0, `ERX_STAT_OFS, 32'h0);
        check("overrun flag", 32'h4, r & 32'h4);
        run_frame(200, 1'b1, 190, 1'b0, 1'b0);
        run_frame(30, 1'b1, -1, 1'b0, 1'b0);
        give_verdict();
    end

    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule
